// File: dtbi_regs.svh
/*
 * register map, field positions, encodings and reset values of the
 * dual time base block. assumes byte addresses on a 32-bit bus.
 */
`ifndef DTBI_REGS_SVH
`define DTBI_REGS_SVH
`define DTBI_OFS_TB0   8'h00
`define DTBI_OFS_TB1   8'h04
`define DTBI_OFS_PSC0  8'h08
`define DTBI_OFS_PSC1  8'h0c
`define DTBI_OFS_STAT  8'h10
`define DTBI_OFS_CLR   8'h14
`define DTBI_OFS_IEN   8'h18
`define DTBI_OFS_GCTL  8'h1c
`define DTBI_OFS_SET   8'h20
`define DTBI_BIT_EN    7
`define DTBI_RST_TBC   8'h00
`define DTBI_RST_PSC   2'b00
`define DTBI_SRC_SYS   2'b00
`define DTBI_SRC_DIV4  2'b01
`define DTBI_DIV4_LAST 2'h3
`define DTBI_TOP_MAX   15'h7fff
`define DTBI_RESP_OK   2'b00
`define DTBI_RESP_ERR  2'b10
`endif

// File: dtbi_pkg.sv
/*
 * types shared by the dual time base block.
 * assumes nothing of its surroundings.
 */
package dtbi_pkg;
    // one time base control byte without its empty bits
    typedef struct packed {
        logic       en;
        logic [2:0] sel;
    } dtbi_tbc_t;
    // sticky request flags, same layout in status, clear, set, enable
    typedef struct packed {
        logic       grp;
        logic [1:0] tick;
    } dtbi_flags_t;
endpackage

// File: dtbi_top.sv
/*
 * dual time base generator with request flags, wake-up, group vector
 * request and interrupt enable handling, reached over axi4-lite.
 * assumes sub_tick is a one-cycle pulse per sub clock period, already
 * synchronous to mclk, and that the cpu pulses irq_ack when it takes
 * the vector and ret_interrupt_return_instr/ret_plain when it returns.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "dtbi_regs.svh"

// prescaler plus power-of-two divider for one time base
module dtbi_tbase (
    input  wire logic              mclk,     // system clock
    input  wire logic              reset,    // async, active high
    input  wire dtbi_pkg::dtbi_tbc_t ctl,    // enable and period select
    input  wire logic [1:0]        src,      // prescaler source select
    input  wire logic              div4,     // one pulse per 4 clocks
    input  wire logic              sub_tick, // sub clock pulse
    output logic                   ovf       // period overflow pulse
);
    import dtbi_pkg::*;
    logic [14:0] cnt_ff;
    logic [14:0] top;
    logic        pt;

    // prescaled clock as an enable pulse; 1x means sub clock
    always_comb begin
        case (src)
            `DTBI_SRC_SYS:  pt = 1'b1;
            `DTBI_SRC_DIV4: pt = div4;
            default:        pt = sub_tick;
        endcase
    end

    // last count is 2^(8+sel)-1
    assign top = `DTBI_TOP_MAX >> (3'd7 - ctl.sel);
    // >= so a shorter period picked mid-count still wraps at once
    assign ovf = ctl.en & pt & (cnt_ff >= top);

    // divider held at zero while off, restarts from zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 15'h0000;
        end else if (!ctl.en) begin
            cnt_ff <= 15'h0000;
        end else if (pt) begin
            cnt_ff <= (cnt_ff >= top) ? 15'h0000 : cnt_ff + 15'h0001;
        end
    end

    hold_clear_a: assert property (@(posedge mclk) disable iff (reset)
        !ctl.en |-> !ovf ##1 cnt_ff == 15'h0000)
        else $error("disabled divider counted or overflowed");
    period_end_a: assert property (@(posedge mclk) disable iff (reset)
        ovf |-> ({1'b0, cnt_ff} >= ((16'h0001 << (4'd8 + ctl.sel)) - 16'h0001)) && pt)
        else $error("overflow before period end");
    sys_src_a: assert property (@(posedge mclk) disable iff (reset)
        (ctl.en && src == 2'b00 && cnt_ff < top) ##1 ctl.en
        |-> cnt_ff == $past(cnt_ff) + 15'h0001)
        else $error("system clock source did not count every cycle");
endmodule

// Behaviour
// - control zero bit 7 enables first time base
// - period select gives 2^(8+sel) prescaled cycles
// - control one bit 7 enables second time base
// - second period select gives 2^(8+sel) cycles
// - bits 6 to 3 read as zero
// - flag rising edge generates wake-up
// - wake-up ignores all enable bits
// - flags stay set until serviced or cleared
// - vector entry clears group flag only
// - entry pushes program counter only
// - interrupt return sets global enable, plain not
// - prescaler source: system, system/4, sub clock
// - overflow sets flag; vector needs global, group and that time base's enable
module dtbi_top #(
    parameter int AW = 8 // axi address width, at least 8
) (
    input  wire logic          mclk,          // 20 MHz system clock
    input  wire logic          reset,         // async, active high
    input  wire logic          sub_tick,      // sub clock pulse
    input  wire logic          irq_ack,       // cpu takes the vector
    input  wire logic          ret_interrupt_return_instr,      // interrupt return done
    input  wire logic          ret_plain,     // plain return done
    input  wire logic [AW-1:0] s_axi_awaddr,  // write address
    input  wire logic          s_axi_awvalid, // write address valid
    output logic               awready_ff,    // write address ready
    input  wire logic [31:0]   s_axi_wdata,   // write data
    input  wire logic [3:0]    s_axi_wstrb,   // write strobes
    input  wire logic          s_axi_wvalid,  // write data valid
    output logic               wready_ff,     // write data ready
    output logic [1:0]         bresp_ff,      // write response
    output logic               bvalid_ff,     // write response valid
    input  wire logic          s_axi_bready,  // response ready
    input  wire logic [AW-1:0] s_axi_araddr,  // read address
    input  wire logic          s_axi_arvalid, // read address valid
    output logic               arready_ff,    // read address ready
    output logic [31:0]        rdata_ff,      // read data
    output logic [1:0]         rresp_ff,      // read response
    output logic               rvalid_ff,     // read data valid
    input  wire logic          s_axi_rready,  // read data ready
    output logic               irq_ff,        // enabled flag pending
    output logic               vec_req_ff,    // group vector request
    output logic               push_pc_ff,    // push only the pc
    output logic               wake_ff,       // wake-up pulse
    output logic               gie_ff         // global irq enable
);
    import dtbi_pkg::*;
    dtbi_tbc_t   tbc_ff [2];
    logic [1:0]  psc_ff [2];
    dtbi_flags_t flag_ff, ien_ff, nxt_flag, clr, setw;
    logic [1:0]  ovf, div_ff;
    logic [AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic        wstrb0_ff, aw_have_ff, w_have_ff;
    logic        nxt_aw_have, nxt_w_have, nxt_bvalid, nxt_rvalid;
    logic        wr_go, wr_hit, rd_go, rd_hit;
    logic [7:0]  wa, ra, wd;
    logic [7:0]  rd_byte;

    // shared system/4 prescaler
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end

    // two identical time bases
    for (genvar i = 0; i < 2; i++) begin : g_tb
        dtbi_tbase u_tb (
            .mclk     (mclk),
            .reset    (reset),
            .ctl      (tbc_ff[i]), // enable off holds divider at zero
            .src      (psc_ff[i]),
            .div4     (div_ff == `DTBI_DIV4_LAST),
            .sub_tick (sub_tick),
            .ovf      (ovf[i])
        );
    end

    // write channel bookkeeping, one write in flight
    assign wr_go       = aw_have_ff & w_have_ff & ~bvalid_ff;
    assign nxt_aw_have = (aw_have_ff | (s_axi_awvalid & awready_ff)) & ~wr_go;
    assign nxt_w_have  = (w_have_ff | (s_axi_wvalid & wready_ff)) & ~wr_go;
    assign nxt_bvalid  = wr_go | (bvalid_ff & ~s_axi_bready);
    assign wa          = awaddr_ff[7:0];
    assign wd          = wdata_ff[7:0];
    // only byte lane 0 carries register bits
    assign wr_hit      = wr_go & wstrb0_ff;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `DTBI_RESP_OK;
            awaddr_ff  <= '0;
            wdata_ff   <= 32'h0000_0000;
            wstrb0_ff  <= 1'b0;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            awready_ff <= ~nxt_aw_have & ~nxt_bvalid;
            wready_ff  <= ~nxt_w_have & ~nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            if (s_axi_awvalid && awready_ff) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff  <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                bresp_ff <= (wa <= `DTBI_OFS_SET && wa[1:0] == 2'b00)
                            ? `DTBI_RESP_OK : `DTBI_RESP_ERR;
            end
        end
    end

    // control registers written by software
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tbc_ff[0] <= dtbi_tbc_t'(4'h0);
            tbc_ff[1] <= dtbi_tbc_t'(4'h0);
            psc_ff[0] <= `DTBI_RST_PSC;
            psc_ff[1] <= `DTBI_RST_PSC;
            ien_ff    <= dtbi_flags_t'(3'h0);
        end else if (wr_hit) begin
            case (wa)
                `DTBI_OFS_TB0:  tbc_ff[0] <= {wd[`DTBI_BIT_EN], wd[2:0]};
                `DTBI_OFS_TB1:  tbc_ff[1] <= {wd[`DTBI_BIT_EN], wd[2:0]};
                `DTBI_OFS_PSC0: psc_ff[0] <= wd[1:0];
                `DTBI_OFS_PSC1: psc_ff[1] <= wd[1:0];
                `DTBI_OFS_IEN:  ien_ff    <= dtbi_flags_t'(wd[2:0]);
                default:        ;
            endcase
        end
    end

    // write-only clear and set strobes for the flags
    assign clr  = dtbi_flags_t'((wr_hit && wa == `DTBI_OFS_CLR) ? wd[2:0] : 3'h0);
    assign setw = dtbi_flags_t'((wr_hit && wa == `DTBI_OFS_SET) ? wd[2:0] : 3'h0);

    // hardware set beats any clear in the same cycle
    always_comb begin
        nxt_flag.tick = (flag_ff.tick & ~clr.tick) | setw.tick | ovf;
        nxt_flag.grp  = (flag_ff.grp & ~clr.grp & ~irq_ack)
                      | setw.grp | (|(ovf & ien_ff.tick));
    end

    // flags, wake-up and interrupt outputs
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            flag_ff    <= dtbi_flags_t'(3'h0);
            wake_ff    <= 1'b0;
            irq_ff     <= 1'b0;
            vec_req_ff <= 1'b0;
            push_pc_ff <= 1'b0;
        end else begin
            flag_ff    <= nxt_flag;
            // any rising flag wakes, enables play no part
            wake_ff    <= |(nxt_flag & ~flag_ff);
            irq_ff     <= |(nxt_flag & ien_ff);
            // vector needs global, group enable and group flag
            vec_req_ff <= gie_ff & ~irq_ack & ien_ff.grp & nxt_flag.grp;
            // entry saves the program counter and nothing else
            push_pc_ff <= irq_ack & vec_req_ff;
        end
    end

    // global enable: entry clears, interrupt_return_instr sets, plain return leaves it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            gie_ff <= 1'b0;
        end else if (irq_ack) begin
            gie_ff <= 1'b0;
        end else if (ret_interrupt_return_instr) begin
            gie_ff <= 1'b1;
        end else if (wr_hit && wa == `DTBI_OFS_GCTL) begin
            gie_ff <= wd[0];
        end
    end

    // read channel, answer one cycle after the address is taken
    assign rd_go      = s_axi_arvalid & arready_ff;
    assign nxt_rvalid = rd_go | (rvalid_ff & ~s_axi_rready);
    assign ra         = s_axi_araddr[7:0];

    always_comb begin
        rd_hit = 1'b1;
        case (ra)
            `DTBI_OFS_TB0:  rd_byte = {tbc_ff[0].en, 4'h0, tbc_ff[0].sel};
            `DTBI_OFS_TB1:  rd_byte = {tbc_ff[1].en, 4'h0, tbc_ff[1].sel};
            `DTBI_OFS_PSC0: rd_byte = {6'h00, psc_ff[0]};
            `DTBI_OFS_PSC1: rd_byte = {6'h00, psc_ff[1]};
            `DTBI_OFS_STAT: rd_byte = {5'h00, flag_ff};
            `DTBI_OFS_IEN:  rd_byte = {5'h00, ien_ff};
            `DTBI_OFS_GCTL: rd_byte = {7'h00, gie_ff};
            `DTBI_OFS_CLR:  rd_byte = 8'h00; // write-only
            `DTBI_OFS_SET:  rd_byte = 8'h00; // write-only
            default: begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `DTBI_RESP_OK;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (rd_go) begin
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= rd_hit ? `DTBI_RESP_OK : `DTBI_RESP_ERR;
            end
        end
    end

    wake_rise_a: assert property (@(posedge mclk) disable iff (reset)
        (!flag_ff.tick[0] && ovf[0]) |=> wake_ff)
        else $error("rising flag gave no wake-up");
    wake_mask_a: assert property (@(posedge mclk) disable iff (reset)
        (ien_ff == 3'h0 && !gie_ff && !flag_ff.tick[1] && ovf[1]) |=> wake_ff)
        else $error("masked source did not wake");
    flag_hold_a: assert property (@(posedge mclk) disable iff (reset)
        (flag_ff.tick[0] && !clr.tick[0]) |=> flag_ff.tick[0])
        else $error("tick flag dropped without a clear");
    ack_group_a: assert property (@(posedge mclk) disable iff (reset)
        (irq_ack && flag_ff.tick[0] && !clr.tick[0] && !(|(ovf & ien_ff.tick))
         && !setw.grp) |=> !flag_ff.grp && flag_ff.tick[0] && !gie_ff)
        else $error("entry did not clear group flag alone");
    ovf_flag_a: assert property (@(posedge mclk) disable iff (reset)
        ovf[1] |=> flag_ff.tick[1] ##1 !vec_req_ff || gie_ff)
        else $error("overflow lost or vector without global enable");
    interrupt_return_instr_set_a: assert property (@(posedge mclk) disable iff (reset)
        (ret_interrupt_return_instr && !irq_ack) |=> gie_ff)
        else $error("interrupt return left global enable low");
    plain_ret_a: assert property (@(posedge mclk) disable iff (reset)
        (ret_plain && !ret_interrupt_return_instr && !gie_ff && !(wr_hit && wa == `DTBI_OFS_GCTL))
        |=> !gie_ff)
        else $error("plain return raised global enable");
    push_pc_a: assert property (@(posedge mclk) disable iff (reset)
        push_pc_ff |-> $past(irq_ack) && $past(vec_req_ff))
        else $error("pc push without a taken vector");
    rsvd_zero_a: assert property (@(posedge mclk) disable iff (reset)
        (rd_go && (ra == `DTBI_OFS_TB0 || ra == `DTBI_OFS_TB1))
        |=> rvalid_ff && rdata_ff[6:3] == 4'h0)
        else $error("unimplemented control bits read nonzero");
endmodule

// File: tb_top.sv
/*
 * self-checking bench for the dual time base block: axi4-lite register
 * access, periods, wake-up, sticky flags, group vector and returns.
 * assumes dtbi_top, dtbi_pkg and dtbi_regs.svh are compiled alongside.
 */
`timescale 1ns/100ps
`include "dtbi_regs.svh"
module tb_top;
    import dtbi_pkg::*;
    logic        mclk      = 1'b0;
    logic        reset     = 1'b1;
    logic        sub_tick  = 1'b0;
    logic        irq_ack   = 1'b0;
    logic        ret_interrupt_return_instr  = 1'b0;
    logic        ret_plain = 1'b0;
    logic [7:0]  awaddr    = 8'h00;
    logic [7:0]  araddr    = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic        awvalid   = 1'b0;
    logic        wvalid    = 1'b0;
    logic        bready    = 1'b0;
    logic        arvalid   = 1'b0;
    logic        rready    = 1'b0;
    logic [2:0]  sub_cnt   = 3'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, vec, push, wake, gie;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          error_cnt = 0;
    int          compares  = 0;
    int          n;

    always #25 mclk = ~mclk;
    // sub clock stand-in: one pulse every 8 system clocks
    always @(posedge mclk) begin
        sub_cnt  <= sub_cnt + 3'h1;
        sub_tick <= (sub_cnt == 3'h7);
    end

    dtbi_top #(.AW(8)) DUT (.mclk(mclk), .reset(reset), .sub_tick(sub_tick),
        .irq_ack(irq_ack), .ret_interrupt_return_instr(ret_interrupt_return_instr), .ret_plain(ret_plain),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .awready_ff(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .wready_ff(wready),
        .bresp_ff(bresp), .bvalid_ff(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .arready_ff(arready),
        .rdata_ff(rdata), .rresp_ff(rresp), .rvalid_ff(rvalid), .s_axi_rready(rready),
        .irq_ff(irq), .vec_req_ff(vec), .push_pc_ff(push), .wake_ff(wake), .gie_ff(gie));

    task automatic tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic win(input string nm, input int lo, input int hi, input int g);
        compares++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic hang;
        error_cnt++;
        $display("MISMATCH bus wait expected answer seen none");
        tally_and_finish();
    endtask

    // ready and answer decided on settled values, released right after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int i;
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge mclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge mclk);
            ta = awready === 1'b1; tw = wready === 1'b1; tb = bvalid === 1'b1; r = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
        if (i == 50) hang();
        else chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int i;
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge mclk);
            ta = arready === 1'b1; tr = rvalid === 1'b1; d = rdata; r = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
        if (i == 50) begin
            hang();
        end else begin
            chk("rdata", {24'h0, ed}, d);
            chk("rresp", {30'h0, er}, {30'h0, r});
        end
    endtask

    // counts cycles until the one-cycle wake pulse, or until the limit
    task automatic wait_wake(input int lim);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (n < lim && wake !== 1'b1);
    endtask

    task automatic t_regs;
        rd(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_TB1, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_PSC0, 8'h00, `DTBI_RESP_OK);
        rd(8'h24, 8'h00, `DTBI_RESP_ERR);
        wr(8'h24, 8'hff, `DTBI_RESP_ERR);
        wr(`DTBI_OFS_TB1, 8'hff, `DTBI_RESP_OK);
        rd(`DTBI_OFS_TB1, 8'h87, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB0, 8'h7a, `DTBI_RESP_OK);
        rd(`DTBI_OFS_TB0, 8'h02, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB1, 8'h00, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
    endtask

    // all enables off: flags still rise and wake the core
    task automatic t_periods;
        wr(`DTBI_OFS_TB0, 8'h80, `DTBI_RESP_OK);
        wait_wake(400);
        win("tb0 sel0 sys", 250, 258, n);
        wr(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_STAT, 8'h01, `DTBI_RESP_OK);
        wr(`DTBI_OFS_CLR, 8'h07, `DTBI_RESP_OK);
        wait_wake(600);
        win("disabled no wake", 600, 600, n);
        rd(`DTBI_OFS_STAT, 8'h00, `DTBI_RESP_OK);
        wr(`DTBI_OFS_PSC1, `DTBI_SRC_DIV4, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB1, 8'h81, `DTBI_RESP_OK);
        wait_wake(2400);
        win("tb1 sel1 div4", 2034, 2052, n);
        wr(`DTBI_OFS_TB1, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_STAT, 8'h02, `DTBI_RESP_OK);
        wr(`DTBI_OFS_PSC0, 8'h02, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB0, 8'h80, `DTBI_RESP_OK);
        wait_wake(2400);
        win("tb0 sel0 sub", 2026, 2058, n);
        wr(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
        wr(`DTBI_OFS_PSC0, 8'h00, `DTBI_RESP_OK);
        wr(`DTBI_OFS_CLR, 8'h07, `DTBI_RESP_OK);
        // longest period on the system clock
        wr(`DTBI_OFS_TB0, 8'h87, `DTBI_RESP_OK);
        wait_wake(33000);
        win("tb0 sel7 sys", 32760, 32776, n);
        wr(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
        wr(`DTBI_OFS_CLR, 8'h07, `DTBI_RESP_OK);
    endtask

    task automatic t_vector;
        wr(`DTBI_OFS_IEN, 8'h07, `DTBI_RESP_OK);
        wr(`DTBI_OFS_GCTL, 8'h01, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB0, 8'h80, `DTBI_RESP_OK);
        wait_wake(400);
        wr(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_STAT, 8'h05, `DTBI_RESP_OK);
        chk("irq", 1, irq);
        chk("vec_req", 1, vec);
        @(posedge mclk) irq_ack <= 1'b1;
        @(posedge mclk) irq_ack <= 1'b0;
        @(negedge mclk);
        chk("push_pc", 1, push);
        chk("gie after entry", 0, gie);
        @(negedge mclk);
        chk("push_pc one cycle", 0, push);
        rd(`DTBI_OFS_STAT, 8'h01, `DTBI_RESP_OK);
        wr(`DTBI_OFS_IEN, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_STAT, 8'h01, `DTBI_RESP_OK);
        chk("irq masked", 0, irq);
        wr(`DTBI_OFS_IEN, 8'h01, `DTBI_RESP_OK);
        // irq settles on the edge the task returns at
        @(negedge mclk);
        chk("irq enabled", 1, irq);
        wr(`DTBI_OFS_CLR, 8'h01, `DTBI_RESP_OK);
        rd(`DTBI_OFS_STAT, 8'h00, `DTBI_RESP_OK);
        chk("irq cleared", 0, irq);
        @(posedge mclk) ret_plain <= 1'b1;
        @(posedge mclk) ret_plain <= 1'b0;
        @(negedge mclk);
        chk("gie plain return", 0, gie);
        @(posedge mclk) ret_interrupt_return_instr <= 1'b1;
        @(posedge mclk) ret_interrupt_return_instr <= 1'b0;
        @(negedge mclk);
        chk("gie interrupt return", 1, gie);
        chk("vec_req no flag", 0, vec);
        wr(`DTBI_OFS_IEN, 8'h00, `DTBI_RESP_OK);
    endtask

    // software presets the flag so the overflow makes no rising edge
    task automatic t_preset;
        wr(`DTBI_OFS_SET, 8'h01, `DTBI_RESP_OK);
        wr(`DTBI_OFS_TB0, 8'h80, `DTBI_RESP_OK);
        wait_wake(400);
        win("preset no wake", 400, 400, n);
        wr(`DTBI_OFS_TB0, 8'h00, `DTBI_RESP_OK);
        rd(`DTBI_OFS_STAT, 8'h01, `DTBI_RESP_OK);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        t_regs();
        t_periods();
        t_vector();
        t_preset();
        tally_and_finish();
    end
endmodule
